/* hw/timebase_ctrl_status.sv */
// time-base counter with mode control, phase load on sync and sticky status
// assumes an apb master on clk, a one-cycle timebase_tick from same-clock logic
//
// Design decisions made here: the APB register port and the placing of the registers.
module timebase_ctrl_status
  import timebase_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timebase_tick,
  input  wire logic        sync_in,
  output logic      [15:0] timebase_count_value,
  output logic             count_direction_flag,
  output logic             irq
);
  import timebase_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  count_mode_e  count_mode_select_q;
  logic         phase_load_enable_q;
  logic         soft_sync_force_q;
  logic [15:0]  phase_value_register_q;
  logic [15:0]  count_q;
  logic [15:0]  count_d;
  logic         dir_q;
  logic         dir_d;
  logic         count_max_latch_q;
  logic         sync_in_latch_q;
  logic [2:0]   mask_q;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         setup;
  logic         access;
  logic         hit;
  logic         wr_en;
  logic         sync_any;
  logic         load;
  logic         turn;
  logic         step_up;
  logic [2:0]   flags;
  logic         clr_max;

  sync_evt_if   sync_bus ();

  // ----------------------------------------------------------------
  // address decode and read mux
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == CTRL_OFFSET) || (a == STATUS_OFFSET) || (a == PHASE_OFFSET) ||
              (a == COUNT_OFFSET) || (a == MASK_OFFSET);
  endfunction

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    is_reg = (a == off);
  endfunction

  assign flags = {count_max_latch_q, sync_in_latch_q, dir_q};

  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = 32'h0000_0000;
    if (is_reg(a, CTRL_OFFSET)) begin
      read_word[MODE_LSB +: 2]  = count_mode_select_q;
      read_word[PHASE_EN_BIT]   = phase_load_enable_q;
    end else if (is_reg(a, STATUS_OFFSET)) begin
      read_word[2:0] = flags;
    end else if (is_reg(a, PHASE_OFFSET)) begin
      read_word[15:0] = phase_value_register_q;
    end else if (is_reg(a, COUNT_OFFSET)) begin
      read_word[15:0] = count_q;
    end else if (is_reg(a, MASK_OFFSET)) begin
      read_word[2:0] = mask_q;
    end
  endfunction

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign hit     = reg_hit(paddr);
  assign pready  = pready_q;
  assign pslverr = access & pready_q & ~hit;
  assign wr_en   = access & pready_q & pwrite & hit;
  assign prdata  = prdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup && !pwrite) begin
        prdata_q <= read_word(paddr);
      end
    end
  end

  // ----------------------------------------------------------------
  // control, phase and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_mode_select_q <= MODE_RESET;
      phase_load_enable_q <= PHASE_EN_RESET;
    end else if (wr_en && is_reg(paddr, CTRL_OFFSET)) begin
      count_mode_select_q <= count_mode_e'(pwdata[MODE_LSB +: 2]);
      phase_load_enable_q <= pwdata[PHASE_EN_BIT];
    end
  end

  // one-cycle pulse, never stored as readable state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_sync_force_q <= 1'b0;
    end else begin
      soft_sync_force_q <= wr_en & is_reg(paddr, CTRL_OFFSET) & pwdata[SOFT_SYNC_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_value_register_q <= PHASE_RESET;
    end else if (wr_en && is_reg(paddr, PHASE_OFFSET)) begin
      phase_value_register_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RESET;
    end else if (wr_en && is_reg(paddr, MASK_OFFSET)) begin
      mask_q <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // sync sources
  // ----------------------------------------------------------------
  sync_in_filter u_sync_in_filter (
    .clk     (clk),
    .rst_n   (rst_n),
    .sync_in (sync_in),
    .evt     (sync_bus.src)
  );

  assign sync_any = sync_bus.sync_evt | soft_sync_force_q;
  assign load     = sync_any & phase_load_enable_q;

  // ----------------------------------------------------------------
  // counter and direction
  // ----------------------------------------------------------------
  assign turn    = dir_q ? (count_q == COUNT_MAX) : (count_q == COUNT_MIN);
  assign step_up = dir_q ^ turn;

  always_comb begin
    count_d = count_q;
    dir_d   = dir_q;
    if (load) begin
      count_d = phase_value_register_q;
    end else if (timebase_tick) begin
      case (count_mode_select_q)
        MODE_UP: begin
          count_d = count_q + 16'h0001;
          dir_d   = 1'b1;
        end
        MODE_DOWN: begin
          count_d = count_q - 16'h0001;
          dir_d   = 1'b0;
        end
        MODE_UPDOWN: begin
          count_d = step_up ? count_q + 16'h0001 : count_q - 16'h0001;
          dir_d   = step_up;
        end
        default: begin
          count_d = count_q;
          dir_d   = dir_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= COUNT_RESET;
      dir_q   <= DIR_RESET;
    end else begin
      count_q <= count_d;
      dir_q   <= dir_d;
    end
  end

  assign timebase_count_value = count_q;
  assign count_direction_flag = dir_q;

  // ----------------------------------------------------------------
  // sticky status flags, set wins over clear
  // ----------------------------------------------------------------
  assign clr_max = wr_en & is_reg(paddr, STATUS_OFFSET) & pwdata[MAX_FLAG_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_max_latch_q <= 1'b0;
    end else if (count_q == COUNT_MAX) begin
      count_max_latch_q <= 1'b1;
    end else if (wr_en && is_reg(paddr, STATUS_OFFSET) && pwdata[MAX_FLAG_BIT]) begin
      count_max_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_in_latch_q <= 1'b0;
    end else if (sync_bus.sync_evt) begin
      sync_in_latch_q <= 1'b1;
    end else if (wr_en && is_reg(paddr, STATUS_OFFSET) && pwdata[SYNC_FLAG_BIT]) begin
      sync_in_latch_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags[2:1] & mask_q[2:1]);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_no_load_when_disabled;
    @(posedge clk) disable iff (!rst_n)
      sync_any && !phase_load_enable_q && count_mode_select_q == MODE_FREEZE
      |=> $stable(count_q);
  endproperty
  a_no_load_when_disabled: assert property (p_no_load_when_disabled)
    else $error("counter changed on sync with phase load disabled");

  property p_load_on_sync;
    @(posedge clk) disable iff (!rst_n)
      sync_any && phase_load_enable_q |=> count_q == $past(phase_value_register_q);
  endproperty
  a_load_on_sync: assert property (p_load_on_sync)
    else $error("phase value not loaded on sync");

  property p_up_count;
    @(posedge clk) disable iff (!rst_n)
      timebase_tick && !load && count_mode_select_q == MODE_UP
      |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_up_count: assert property (p_up_count)
    else $error("up mode did not increment");

  property p_down_count;
    @(posedge clk) disable iff (!rst_n)
      timebase_tick && !load && count_mode_select_q == MODE_DOWN
      |=> count_q == $past(count_q) - 16'h0001 && !dir_q;
  endproperty
  a_down_count: assert property (p_down_count)
    else $error("down mode did not decrement");

  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
      count_mode_select_q == MODE_FREEZE && !load |=> $stable(count_q) && $stable(dir_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("frozen counter moved");

  property p_max_flag;
    @(posedge clk) disable iff (!rst_n)
      count_q == COUNT_MAX |=> count_max_latch_q ##1 (count_max_latch_q || $past(clr_max));
  endproperty
  a_max_flag: assert property (p_max_flag)
    else $error("max flag not held after reaching 0xffff");

  property p_sync_flag;
    @(posedge clk) disable iff (!rst_n)
      sync_bus.sync_evt |=> sync_in_latch_q;
  endproperty
  a_sync_flag: assert property (p_sync_flag)
    else $error("sync flag not set on external sync");

  property p_w1c_sync;
    @(posedge clk) disable iff (!rst_n)
      wr_en && is_reg(paddr, STATUS_OFFSET) && pwdata[SYNC_FLAG_BIT] && !sync_bus.sync_evt
      |=> !sync_in_latch_q;
  endproperty
  a_w1c_sync: assert property (p_w1c_sync)
    else $error("sync flag not cleared by write one");

  property p_up_dir;
    @(posedge clk) disable iff (!rst_n)
      timebase_tick && !load && count_mode_select_q == MODE_UP |=> dir_q;
  endproperty
  a_up_dir: assert property (p_up_dir)
    else $error("direction not up in up mode");

  property p_soft_pulse;
    @(posedge clk) disable iff (!rst_n)
      soft_sync_force_q |=> !soft_sync_force_q;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse)
    else $error("soft sync longer than one cycle");

  property p_status_reserved;
    @(posedge clk) disable iff (!rst_n)
      setup && !pwrite && is_reg(paddr, STATUS_OFFSET) |=> prdata[31:3] == 29'h0;
  endproperty
  a_status_reserved: assert property (p_status_reserved)
    else $error("reserved status bits not zero");

  property p_turn_at_top;
    @(posedge clk) disable iff (!rst_n)
      timebase_tick && !load && count_mode_select_q == MODE_UPDOWN && dir_q && count_q == COUNT_MAX
      |=> !dir_q && count_q == 16'hfffe;
  endproperty
  a_turn_at_top: assert property (p_turn_at_top)
    else $error("up-down did not reverse at top");

  c_load:     cover property (@(posedge clk) disable iff (!rst_n) load);
  c_turn:     cover property (@(posedge clk) disable iff (!rst_n) $fell(dir_q));
  c_irq:      cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  c_max_seen: cover property (@(posedge clk) disable iff (!rst_n) $rose(count_max_latch_q));

endmodule

/* shared/timebase_pkg.sv */
// constants, field layout and mode encoding of the time-base control/status slice
// assumes a 32-bit apb register bus and a 16-bit counter on a single clock
//
// Overview of operation
// - phase load enable clear: sync events never load the counter from phase.
// - phase load enable set: any sync, external or forced, loads phase into counter.
// - mode 00 counts up, 01 down, 10 up then down, 11 freezes.
// - count mode resets to 11, counter frozen until software picks a mode.
// - mode change acts at the next tick, counting on from the held value.
// - max flag, status bit 2, sets when counter is 0xffff and sticks.
// - sync flag, status bit 1, sets on external sync and sticks.
// - writing 1 clears a sticky flag, writing 0 leaves it alone.
// - direction bit 0 reads 1 while counting up, 0 while counting down.
// - direction bit resets to 1, meaningless until a counting mode is chosen.
// - writing 1 to soft sync force makes one sync pulse; bit reads 0.
package timebase_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  PHASE_OFFSET  = 8'h08;
  localparam logic [7:0]  COUNT_OFFSET  = 8'h0c;
  localparam logic [7:0]  MASK_OFFSET   = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          MODE_LSB      = 0;
  localparam int          PHASE_EN_BIT  = 2;
  localparam int          SOFT_SYNC_BIT = 6;
  localparam int          DIR_BIT       = 0;
  localparam int          SYNC_FLAG_BIT = 1;
  localparam int          MAX_FLAG_BIT  = 2;

  // ----------------------------------------------------------------
  // modes and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_UP     = 2'h0,
    MODE_DOWN   = 2'h1,
    MODE_UPDOWN = 2'h2,
    MODE_FREEZE = 2'h3
  } count_mode_e;

  localparam count_mode_e MODE_RESET     = MODE_FREEZE;
  localparam logic        DIR_RESET      = 1'b1;
  localparam logic        PHASE_EN_RESET = 1'b0;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] PHASE_RESET    = 16'h0000;
  localparam logic [2:0]  MASK_RESET     = 3'h0;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;
  localparam logic [15:0] COUNT_MIN      = 16'h0000;
  localparam int          SYNC_STAGES    = 3;

endpackage

/* shared/sync_evt_if.sv */
// carrier for the qualified external sync event between the input filter and the counter
// assumes both ends run on the same clock
interface sync_evt_if;
  logic sync_evt;
  modport src (output sync_evt);
  modport dst (input  sync_evt);
endinterface

/* hw/sync_in_filter.sv */
// three-flop synchroniser and rising-edge qualifier for the peer sync input
// assumes sync_in is asynchronous to clk and held for at least three clocks
module sync_in_filter
  import timebase_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sync_in,
  sync_evt_if.src          evt
);

  logic [SYNC_STAGES-1:0] stage_q;
  logic                   level_q;
  logic                   evt_q;
  logic                   agree;

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[SYNC_STAGES-2:0], sync_in};
    end
  end

  assign agree = (stage_q[1] == stage_q[2]);

  // ----------------------------------------------------------------
  // agreed level and one-cycle event on its rise
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
      evt_q   <= 1'b0;
    end else begin
      if (agree) begin
        level_q <= stage_q[2];
      end
      evt_q <= agree & stage_q[2] & ~level_q;
    end
  end

  assign evt.sync_evt = evt_q;

endmodule

/* verification/peer_sync_model.sv */
// peer module model: raises the sync level on request for a chosen time
// assumes the block's clock; fire is a one-cycle request from the bench
module peer_sync_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       fire,
  input  wire logic [2:0] hold,
  output logic            sync_in,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // pulse timer
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (fire && cnt_q == 4'h0) begin
      cnt_q <= {1'b0, hold} + 4'h6;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // high for hold+3 clocks, then low for at least 3
  assign sync_in = (cnt_q > 4'h3);
  assign busy    = (cnt_q != 4'h0);
endmodule

/* verification/pwm_timebase_counter_ctrl_status_tb.sv */
// self-checking bench for the time-base control/status slice
// assumes timebase_pkg and the peer sync model are compiled first
module pwm_timebase_counter_ctrl_status_tb import timebase_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic        tick = 1'b0;
  logic        sync_fire = 1'b0;
  logic [2:0]  hold = 3'h0;
  logic [31:0] seed = 32'h8378d028;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] timebase_count_value;
  logic        count_direction_flag;
  logic        irq;
  logic        sync_in;
  logic        peer_busy;
  int          err_total = 0;
  int          comparisons = 0;

  initial begin
    forever #12.5 clk = ~clk;
  end

  timebase_ctrl_status timebase_ctrl_status_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timebase_tick(tick), .sync_in(sync_in), .timebase_count_value(timebase_count_value),
    .count_direction_flag(count_direction_flag), .irq(irq));

  peer_sync_model peer_sync_model_i (.clk(clk), .rst_n(rst_n), .fire(sync_fire), .hold(hold),
    .sync_in(sync_in), .busy(peer_busy));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] step_n(input logic [15:0] v, input count_mode_e m, input int k);
    for (int i = 0; i < k; i++) begin
      if (m == MODE_UP) begin
        v = v + 16'h1;
      end else if (m == MODE_DOWN) begin
        v = v - 16'h1;
      end
    end
    return v;
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      $display("MISMATCH t=%0t no pready", $time);
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk_word(r, exp, what);
    chk_bit(e, 1'b0, "mapped read error");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask

  task automatic fire();
    logic [31:0] r;
    int          n;
    r = rnd();
    @(posedge clk);
    hold <= r[2:0];
    sync_fire <= 1'b1;
    @(posedge clk);
    sync_fire <= 1'b0;
    idle(2);
    n = 0;
    while (peer_busy && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      err_total++;
      $display("MISMATCH t=%0t peer stuck busy", $time);
      report_and_stop();
    end
    idle(2);
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    logic [15:0] c;
    int          n;
    int          k;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(CTRL_OFFSET, 32'h3, "ctrl reset");
    rd_chk(STATUS_OFFSET, 32'h1, "status reset");
    ticks(4);
    rd_chk(COUNT_OFFSET, 32'h0, "frozen count");
    note("reset");
    n = int'(rnd() % 32'd40) + 2;
    k = int'(rnd() % n) + 1;
    wr(CTRL_OFFSET, {30'h0, MODE_UP});
    ticks(n);
    c = step_n(16'h0, MODE_UP, n);
    rd_chk(COUNT_OFFSET, {16'h0, c}, "up count");
    chk_bit(count_direction_flag, 1'b1, "dir up");
    wr(CTRL_OFFSET, {30'h0, MODE_DOWN});
    ticks(k);
    c = step_n(c, MODE_DOWN, k);
    rd_chk(COUNT_OFFSET, {16'h0, c}, "down count");
    wr(STATUS_OFFSET, 32'hfffffff8);
    rd_chk(STATUS_OFFSET, 32'h0, "status down");
    note("up_down");
    wr(PHASE_OFFSET, 32'hfffe);
    wr(CTRL_OFFSET, 32'h44);
    idle(2);
    rd_chk(CTRL_OFFSET, 32'h4, "force reads 0");
    rd_chk(COUNT_OFFSET, 32'hfffe, "soft load");
    ticks(1);
    rd_chk(STATUS_OFFSET, 32'h5, "max set");
    ticks(1);
    rd_chk(COUNT_OFFSET, 32'h0, "wrap");
    wr(STATUS_OFFSET, 32'h0);
    rd_chk(STATUS_OFFSET, 32'h5, "max sticky");
    wr(STATUS_OFFSET, 32'h4);
    rd_chk(STATUS_OFFSET, 32'h1, "max clear");
    note("max_flag");
    wr(CTRL_OFFSET, 32'h46);
    idle(2);
    ticks(3);
    rd_chk(COUNT_OFFSET, 32'hfffd, "turn at top");
    chk_bit(count_direction_flag, 1'b0, "dir after top");
    wr(PHASE_OFFSET, 32'h1);
    wr(CTRL_OFFSET, 32'h46);
    idle(2);
    ticks(3);
    rd_chk(COUNT_OFFSET, 32'h2, "turn at bottom");
    chk_bit(count_direction_flag, 1'b1, "dir after bottom");
    note("updown_turns");
    wr(STATUS_OFFSET, 32'h4);
    wr(CTRL_OFFSET, 32'h43);
    fire();
    rd_chk(COUNT_OFFSET, 32'h2, "no load");
    rd_chk(STATUS_OFFSET, 32'h3, "sync flag");
    wr(MASK_OFFSET, 32'h6);
    idle(2);
    chk_bit(irq, 1'b1, "irq raised");
    wr(MASK_OFFSET, 32'h4);
    idle(2);
    chk_bit(irq, 1'b0, "irq masked");
    wr(STATUS_OFFSET, 32'h2);
    rd_chk(STATUS_OFFSET, 32'h1, "sync clear");
    wr(MASK_OFFSET, 32'h6);
    idle(2);
    chk_bit(irq, 1'b0, "irq cleared");
    note("sync_irq");
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      wr(PHASE_OFFSET, {16'h0, r[15:0]});
      wr(CTRL_OFFSET, (i % 2 == 0) ? 32'h7 : 32'h47);
      if (i % 2 == 0) begin
        fire();
      end
      idle(2);
      rd_chk(COUNT_OFFSET, {16'h0, r[15:0]}, "sync load");
      chk_word({16'h0, timebase_count_value}, {16'h0, r[15:0]}, "count port");
    end
    note("phase_load");
    apb(1'b1, 8'h20, 32'hffffffff, r, e);
    chk_bit(e, 1'b1, "write refused");
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk_bit(e, 1'b1, "read refused");
    chk_word(r, 32'h0, "unmapped data");
    note("unmapped");
    report_and_stop();
  end
endmodule
